// [design/adc_seq_pkg.sv]
// shared constants and types for the converter sequencer
package adc_seq_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_CLKCTL  = 8'h08;
   localparam logic [7:0] OFS_SAMPCTL = 8'h0c;
   localparam logic [7:0] OFS_CHSEL0  = 8'h10;
   localparam logic [7:0] OFS_CHSEL3  = 8'h1c;
   localparam logic [7:0] OFS_DIVSEL  = 8'h20;
   localparam logic [7:0] OFS_DYNPU   = 8'h24;
   localparam logic [7:0] OFS_LPCFG   = 8'h28;
   localparam logic [7:0] OFS_FIFO    = 8'h2c;

   // ==========================================================
   // field positions
   localparam int CTRL_START  = 0;
   localparam int CTRL_CONT   = 1;
   localparam int CTRL_HWEN   = 2;
   localparam int CTRL_STOP   = 3;
   localparam int CTRL_SLOTS  = 4;
   localparam int CTRL_FMT    = 8;
   localparam int STAT_OVF    = 16;

   // ==========================================================
   // reset values and timing
   localparam logic [3:0] SLOTS_RST   = 4'h0;
   localparam logic [7:0] TRACK_RST   = 8'h04;
   localparam logic [7:0] IDLE_RST    = 8'h00;
   localparam logic [3:0] CLKDIV_RST  = 4'h0;
   localparam logic [8:0] TRACK_BASE  = 9'h004;
   localparam logic [8:0] HOLD_BASE   = 9'h011;
   localparam logic [3:0] DIV_MAXPOW  = 4'h3;
   localparam int         NUM_CH      = 13;
   localparam int         LP_LAST_CH  = 11;
   localparam int         FIFO_DEPTH  = 8;

   // ==========================================================
   // encodings
   localparam logic [1:0] SRC_SYS     = 2'h0;
   localparam logic [1:0] SRC_EXT     = 2'h1;
   localparam logic [1:0] SRC_IOSC    = 2'h2;
   localparam logic [1:0] SRC_XOSC    = 2'h3;
   localparam logic [1:0] DIV_PASS    = 2'h0;
   localparam logic [1:0] DIV_SMALL   = 2'h1;
   localparam logic [1:0] DIV_LARGE   = 2'h2;
   localparam logic [1:0] FMT_RIGHT   = 2'h0;
   localparam logic [1:0] FMT_LEFT    = 2'h1;
   localparam logic [1:0] FMT_TAGGED  = 2'h2;

   typedef enum logic { SEQ_IDLE, SEQ_RUN } seq_state_t;

   typedef struct packed {
      logic [3:0]  channel;
      logic [11:0] data;
   } fifo_entry_t;

endpackage

// [design/tick_divider.sv]
// divides a tick stream by two to the power of (div + 1) for div 0-3; above 3 it passes
`timescale 1ns/100ps
`default_nettype none
module tick_divider
   import adc_seq_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       tick_in,
   input  wire logic [3:0] div,
   output logic            tick_out
);
   logic [3:0] cnt_q;
   logic [3:0] term;

   // ==========================================================
   // divider
   assign term = (div > DIV_MAXPOW) ? 4'h0
               : 4'((5'h02 << div) - 5'h01);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 4'h0;
      end else if (tick_in) begin
         cnt_q <= (cnt_q >= term) ? 4'h0 : cnt_q + 4'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= tick_in && (cnt_q >= term);
      end
   end
endmodule
`default_nettype wire

// [design/adc_sequencer.sv]
// converter sequencer, sample timing and register slave
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - A sequence converts slot 0 first, then later slots in order.
// - The slot count is zero based: value N converts N plus one slots.
// - Each slot takes its channel from its own of sixteen id fields.
// - Single or repeating sequences start by software or hardware.
// - Each result is pushed into a result fifo, dropped if it is full, and read out in a chosen format.
// - Ids 0-11 are external inputs, 12 supply, 13 temp, 14 core, 15 gnd.
// - Divider select 0 passes, 1 halves by 5k, 2 halves by 50k.
// - Dynamic bit 0 keeps a divider on, 1 only while converting it.
// - Low-power divider offs touch channels 0-11; 12 always goes off.
// - Clock select 0 system, 1 external, 2 internal osc, 3 ext osc.
// - Divider 0-3 divides by two to the (div+1); above 3 passes.
// - Sample clock is high for track then low for hold.
// - Track lasts 4 plus the track count; software keeps it 8 or more.
// - Hold lasts 17 plus the idle count.
module adc_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic [31:0]              hrdata,
   input  wire logic                hw_trigger,
   input  wire logic                ext_clk_in,
   input  wire logic                int_osc_in,
   input  wire logic                ext_osc_in,
   input  wire logic                low_power,
   input  wire logic [11:0]         conv_result,
   output logic                     sample_clk,
   output logic [3:0]               mux_channel,
   output logic [NUM_CH-1:0]        div_enable,
   output logic [NUM_CH-1:0]        div_large
);
   // ==========================================================
   // registers
   logic        cont_q, hwen_q, stop_q, ovf_q;
   logic [3:0]  slots_q, clkdiv_q, slot_q;
   logic [1:0]  fmt_q, clksel_q;
   logic [7:0]  track_q, idle_q;
   logic [3:0]  slot_id_q [16];
   logic [1:0]  divsel_q [NUM_CH];
   logic [NUM_CH-1:0] dynpu_q;
   logic        small_off_q, large_off_q;
   logic        wr_q;
   logic [7:0]  wa_q;
   logic        trig_prev_q, ext_prev_q, iosc_prev_q, xosc_prev_q;
   seq_state_t  state_q;
   logic        phase_hold_q;
   logic [8:0]  cnt_q;
   fifo_entry_t fifo_q [FIFO_DEPTH];
   logic [2:0]  wp_q, rp_q;
   logic [3:0]  count_q;
   logic        src_tick, sar_tick, addr_ok, start_req, push, pop, last;
   logic        full, empty, rd_fifo, done;
   logic [8:0]  track_len, hold_len;
   logic [7:0]  a_addr;

   assign a_addr  = haddr[7:0];
   assign addr_ok = hsel && htrans[1] && hready;
   assign full    = (count_q == 4'(FIFO_DEPTH));
   assign empty   = (count_q == 4'h0);
   assign rd_fifo = addr_ok && !hwrite && (a_addr == OFS_FIFO);
   assign pop     = rd_fifo && !empty;

   // ==========================================================
   // clock source and divider
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_prev_q  <= 1'b0;
         iosc_prev_q <= 1'b0;
         xosc_prev_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         ext_prev_q  <= ext_clk_in;
         iosc_prev_q <= int_osc_in;
         xosc_prev_q <= ext_osc_in;
         trig_prev_q <= hw_trigger;
      end
   end

   always_comb begin
      if (clksel_q == SRC_SYS) begin
         src_tick = 1'b1;
      end else if (clksel_q == SRC_EXT) begin
         src_tick = ext_clk_in && !ext_prev_q;
      end else if (clksel_q == SRC_IOSC) begin
         src_tick = int_osc_in && !iosc_prev_q;
      end else begin
         src_tick = ext_osc_in && !xosc_prev_q;
      end
   end

   // rate limit on the result is software's concern
   tick_divider u_sar_div (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .tick_in  (src_tick),
      .div      (clkdiv_q),
      .tick_out (sar_tick)
   );

   // ==========================================================
   // register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
      end else begin
         wr_q <= addr_ok && hwrite;
         wa_q <= a_addr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cont_q      <= 1'b0;
         hwen_q      <= 1'b0;
         slots_q     <= SLOTS_RST;
         fmt_q       <= FMT_RIGHT;
         clksel_q    <= SRC_SYS;
         clkdiv_q    <= CLKDIV_RST;
         track_q     <= TRACK_RST;
         idle_q      <= IDLE_RST;
         dynpu_q     <= '0;
         small_off_q <= 1'b0;
         large_off_q <= 1'b0;
         for (int i = 0; i < 16; i++) slot_id_q[i] <= 4'h0;
         for (int i = 0; i < NUM_CH; i++) divsel_q[i] <= DIV_PASS;
      end else if (wr_q) begin
         if (wa_q == OFS_CTRL) begin
            cont_q  <= hwdata[CTRL_CONT];
            hwen_q  <= hwdata[CTRL_HWEN];
            slots_q <= hwdata[CTRL_SLOTS +: 4];
            fmt_q   <= hwdata[CTRL_FMT +: 2];
         end else if (wa_q == OFS_CLKCTL) begin
            clksel_q <= hwdata[1:0];
            clkdiv_q <= hwdata[7:4];
         end else if (wa_q == OFS_SAMPCTL) begin
            track_q <= hwdata[7:0];
            idle_q  <= hwdata[15:8];
         end else if (wa_q >= OFS_CHSEL0 && wa_q <= OFS_CHSEL3) begin
            // four slots per word, id in low nibble of each byte
            for (int k = 0; k < 4; k++)
               slot_id_q[{wa_q[3:2], 2'(k)}] <= hwdata[8*k +: 4];
         end else if (wa_q == OFS_DIVSEL) begin
            for (int i = 0; i < NUM_CH; i++)
               divsel_q[i] <= hwdata[2*i +: 2];
         end else if (wa_q == OFS_DYNPU) begin
            dynpu_q <= hwdata[NUM_CH-1:0];
         end else if (wa_q == OFS_LPCFG) begin
            small_off_q <= hwdata[0];
            large_off_q <= hwdata[1];
         end
      end
   end

   // ==========================================================
   // sequencer
   assign start_req = (wr_q && wa_q == OFS_CTRL && hwdata[CTRL_START])
                    || (hwen_q && hw_trigger && !trig_prev_q);
   assign track_len = TRACK_BASE + 9'(track_q);
   assign hold_len  = HOLD_BASE + 9'(idle_q);
   assign done      = state_q == SEQ_RUN && sar_tick && phase_hold_q
                    && (cnt_q + 9'h001 == hold_len);
   assign last      = (slot_q == slots_q);
   assign push      = done;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_q <= 1'b0;
      end else if (state_q == SEQ_IDLE) begin
         stop_q <= 1'b0;
      end else if (wr_q && wa_q == OFS_CTRL && hwdata[CTRL_STOP]) begin
         stop_q <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q      <= SEQ_IDLE;
         slot_q       <= 4'h0;
         phase_hold_q <= 1'b0;
         cnt_q        <= 9'h000;
         sample_clk   <= 1'b0;
      end else begin
         case (state_q)
            SEQ_IDLE: begin
               if (start_req) begin
                  state_q      <= SEQ_RUN;
                  slot_q       <= 4'h0;
                  phase_hold_q <= 1'b0;
                  cnt_q        <= 9'h000;
                  sample_clk   <= 1'b1;
               end
            end
            SEQ_RUN: begin
               if (sar_tick && !phase_hold_q) begin
                  if (cnt_q + 9'h001 == track_len) begin
                     phase_hold_q <= 1'b1;
                     cnt_q        <= 9'h000;
                     sample_clk   <= 1'b0;
                  end else begin
                     cnt_q <= cnt_q + 9'h001;
                  end
               end else if (sar_tick) begin
                  if (done) begin
                     phase_hold_q <= 1'b0;
                     cnt_q        <= 9'h000;
                     if (last && (!cont_q || stop_q)) begin
                        state_q    <= SEQ_IDLE;
                        sample_clk <= 1'b0;
                     end else begin
                        slot_q     <= last ? 4'h0 : slot_q + 4'h1;
                        sample_clk <= 1'b1;
                     end
                  end else begin
                     cnt_q <= cnt_q + 9'h001;
                  end
               end
            end
            default: state_q <= SEQ_IDLE;
         endcase
      end
   end

   // ids 0..11 external, 12 supply, 13 temp, 14 core, 15 ground
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mux_channel <= 4'h0;
      end else begin
         mux_channel <= slot_id_q[slot_q];
      end
   end

   // ==========================================================
   // input dividers
   for (genvar c = 0; c < NUM_CH; c++) begin : g_div
      logic active, lp_off;
      assign active = state_q == SEQ_RUN && mux_channel == 4'(c);
      if (c <= LP_LAST_CH) begin : g_lp
         assign lp_off = low_power &&
            ((divsel_q[c] == DIV_SMALL && small_off_q)
             || (divsel_q[c] == DIV_LARGE && large_off_q));
      end else begin : g_sup
         assign lp_off = low_power;
      end
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            div_enable[c] <= 1'b0;
            div_large[c]  <= 1'b0;
         end else begin
            div_enable[c] <= (divsel_q[c] == DIV_SMALL
                              || divsel_q[c] == DIV_LARGE)
                             && (!dynpu_q[c] || active)
                             && !lp_off;
            div_large[c]  <= divsel_q[c] == DIV_LARGE;
         end
      end
   end

   // ==========================================================
   // result fifo; a push into a full fifo is dropped and flagged
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_q    <= 3'h0;
         rp_q    <= 3'h0;
         count_q <= 4'h0;
         for (int i = 0; i < FIFO_DEPTH; i++) fifo_q[i] <= '0;
      end else begin
         if (push && !full) begin
            fifo_q[wp_q] <= '{channel: mux_channel, data: conv_result};
            wp_q         <= wp_q + 3'h1;
         end
         if (pop) rp_q <= rp_q + 3'h1;
         count_q <= count_q + 4'(push && !full) - 4'(pop);
      end
   end

   // set wins over a write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_q <= 1'b0;
      end else if (push && full) begin
         ovf_q <= 1'b1;
      end else if (wr_q && wa_q == OFS_STATUS && hwdata[STAT_OVF]) begin
         ovf_q <= 1'b0;
      end
   end

   // ==========================================================
   // read data, prepared in the address phase for zero wait
   function automatic logic [31:0] fmt_word(fifo_entry_t e, logic [1:0] f);
      logic [31:0] w;
      w = {20'h00000, e.data};
      if (f == FMT_LEFT) w = {16'h0000, e.data, 4'h0};
      else if (f == FMT_TAGGED) w = {12'h000, e.channel, 4'h0, e.data};
      return w;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (addr_ok && !hwrite) begin
         if (a_addr == OFS_CTRL) begin
            hrdata <= {22'h000000, fmt_q, slots_q, 1'b0, hwen_q,
                       cont_q, 1'b0};
         end else if (a_addr == OFS_STATUS) begin
            hrdata <= {15'h0000, ovf_q, 2'h0, full, empty, count_q,
                       slot_q, 2'h0, stop_q, state_q == SEQ_RUN};
         end else if (a_addr == OFS_CLKCTL) begin
            hrdata <= {24'h000000, clkdiv_q, 2'h0, clksel_q};
         end else if (a_addr == OFS_SAMPCTL) begin
            hrdata <= {16'h0000, idle_q, track_q};
         end else if (a_addr >= OFS_CHSEL0 && a_addr <= OFS_CHSEL3) begin
            for (int k = 0; k < 4; k++)
               hrdata[8*k +: 8] <= {4'h0, slot_id_q[{a_addr[3:2], 2'(k)}]};
         end else if (a_addr == OFS_DIVSEL) begin
            hrdata <= 32'h00000000;
            for (int i = 0; i < NUM_CH; i++)
               hrdata[2*i +: 2] <= divsel_q[i];
         end else if (a_addr == OFS_DYNPU) begin
            hrdata <= {19'h00000, dynpu_q};
         end else if (a_addr == OFS_LPCFG) begin
            hrdata <= {30'h00000000, large_off_q, small_off_q};
         end else if (a_addr == OFS_FIFO) begin
            hrdata <= empty ? 32'h00000000 : fmt_word(fifo_q[rp_q], fmt_q);
         end else begin
            hrdata <= 32'h00000000;
         end
      end
   end

   // ==========================================================
   // checks
   logic [8:0] hi_len_q, lo_len_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_len_q <= 9'h000;
         lo_len_q <= 9'h000;
      end else begin
         if (!sample_clk) hi_len_q <= 9'h000;
         else if (sar_tick) hi_len_q <= hi_len_q + 9'h001;
         if (sample_clk) lo_len_q <= 9'h000;
         else if (sar_tick && state_q == SEQ_RUN)
            lo_len_q <= lo_len_q + 9'h001;
      end
   end

   a_first_slot: assert property (@(posedge hclk) disable iff (!hresetn)
      state_q == SEQ_IDLE && start_req |=> slot_q == 4'h0 && sample_clk)
      else $error("sequence did not start at slot 0");
   a_single_end: assert property (@(posedge hclk) disable iff (!hresetn)
      done && last && !cont_q |=> state_q == SEQ_IDLE)
      else $error("single sequence overran slot count");
   a_slot_step: assert property (@(posedge hclk) disable iff (!hresetn)
      done && !last |=> slot_q == $past(slot_q) + 4'h1)
      else $error("slot did not advance by one");
   a_cont_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
      done && last && cont_q && !stop_q |=> state_q == SEQ_RUN && slot_q == 0)
      else $error("continuous sequence did not wrap");
   a_mux_follow: assert property (@(posedge hclk) disable iff (!hresetn)
      state_q == SEQ_RUN |=> mux_channel == $past(slot_id_q[slot_q]))
      else $error("mux channel not from slot id");
   a_track_len: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(sample_clk) && state_q == SEQ_RUN |-> hi_len_q == track_len)
      else $error("track phase length wrong");
   a_hold_len: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(sample_clk) && $past(state_q) == SEQ_RUN
      |-> lo_len_q == hold_len)
      else $error("hold phase length wrong");
   a_fifo_push: assert property (@(posedge hclk) disable iff (!hresetn)
      push && !full && !pop |=> count_q == $past(count_q) + 4'h1)
      else $error("result not pushed");
   a_sar_pass: assert property (@(posedge hclk) disable iff (!hresetn)
      clkdiv_q > DIV_MAXPOW && $stable(clkdiv_q) |=> sar_tick == $past(src_tick))
      else $error("undivided clock not passed");
   a_lp_supply: assert property (@(posedge hclk) disable iff (!hresetn)
      low_power |=> !div_enable[NUM_CH-1])
      else $error("channel 12 divider on in low power");
   a_div_static: assert property (@(posedge hclk) disable iff (!hresetn)
      divsel_q[0] == DIV_SMALL && !dynpu_q[0] && !low_power |=> div_enable[0])
      else $error("static divider not enabled");
endmodule
`default_nettype wire

// [tb/conv_model.sv]
// behavioural converter core and input multiplexer facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module conv_model (
   input  wire logic        sample_clk,
   input  wire logic [3:0]  mux_channel,
   output logic [11:0]      conv_result
);
   // ==========================================================
   // result
   // valid only in hold; during track the lines show the inverse,
   // so a sequencer sampling at the wrong moment reads garbage
   always_comb begin
      if (sample_clk == 1'b0) begin
         conv_result = {8'hc3, mux_channel};
      end else begin
         conv_result = ~{8'hc3, mux_channel};
      end
   end
endmodule
`default_nettype wire

// [tb/tb_adc_sequencer.sv]
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_adc_sequencer import adc_seq_pkg::*;;
   logic              hclk = 1'b0;
   logic              hresetn = 1'b0;
   logic              hsel = 1'b0;
   logic              hwrite = 1'b0;
   logic              hw_trigger = 1'b0;
   logic              low_power = 1'b0;
   logic              ext_clk_in = 1'b0;
   logic              int_osc_in = 1'b0;
   logic              ext_osc_in = 1'b0;
   logic [31:0]       haddr = 32'h0;
   logic [31:0]       hwdata = 32'h0;
   logic [1:0]        htrans = 2'h0;
   logic [2:0]        hsize = 3'h2;
   logic [7:0]        tcnt = 8'h00;
   logic              hreadyout;
   logic              hresp;
   logic [31:0]       hrdata;
   logic              sample_clk;
   logic [3:0]        mux_channel;
   logic [NUM_CH-1:0] div_enable;
   logic [NUM_CH-1:0] div_large;
   logic [11:0]       conv_result;
   logic [31:0]       rd;
   int                n_mismatch = 0;
   int                comparisons = 0;

   always #5 hclk = ~hclk;

   // ==========================================================
   // source clocks: 25, 12.5 and 50 MHz tick streams
   always @(posedge hclk) begin
      tcnt <= tcnt + 8'h01;
      ext_clk_in <= tcnt[1];
      int_osc_in <= tcnt[2];
      ext_osc_in <= tcnt[0];
   end

   adc_sequencer u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .hw_trigger(hw_trigger), .ext_clk_in(ext_clk_in),
      .int_osc_in(int_osc_in), .ext_osc_in(ext_osc_in),
      .low_power(low_power), .conv_result(conv_result),
      .sample_clk(sample_clk), .mux_channel(mux_channel),
      .div_enable(div_enable), .div_large(div_large)
   );

   conv_model u_model (
      .sample_clk(sample_clk), .mux_channel(mux_channel),
      .conv_result(conv_result)
   );

   // ==========================================================
   // helpers
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, rd);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 1000; i++) begin
         ahb(1'b0, OFS_STATUS, 32'h0, rd);
         if (rd[0] === 1'b0) break;
      end
   endtask

   // first slot's hold and second slot's track: their edges all fall on approximation ticks
   task automatic measure(output int hi, output int lo);
      hi = 0;
      lo = 0;
      while (sample_clk !== 1'b1 && lo < 2000) begin @(posedge hclk); lo++; end
      while (sample_clk === 1'b1 && hi < 2000) begin @(posedge hclk); hi++; end
      hi = 0;
      lo = 0;
      while (sample_clk === 1'b0 && lo < 2000) begin @(posedge hclk); lo++; end
      while (sample_clk === 1'b1 && hi < 2000) begin @(posedge hclk); hi++; end
   endtask

   // ==========================================================
   // scenarios
   task automatic reset_regs;
      rdc(OFS_CTRL, 32'h0);
      rdc(OFS_CLKCTL, 32'h0);
      rdc(OFS_SAMPCTL, {16'h0, IDLE_RST, TRACK_RST});
      rdc(OFS_STATUS, 32'h0000_1000);
      chk(hresp, 1'b0);
      wr(8'h3c, 32'hffff_ffff);
      rdc(8'h3c, 32'h0);
   endtask

   // p = hclk cycles per approximation tick, kept at 25 MHz or slower
   task automatic seq_timing(input logic [1:0] src, input logic [3:0] div,
                             input logic [7:0] trk, input logic [7:0] idl,
                             input int p);
      int hi;
      int lo;
      wr(OFS_CLKCTL, {24'h0, div, 2'b00, src});
      wr(OFS_SAMPCTL, {16'h0, idl, trk});
      wr(OFS_CHSEL0, 32'h0f0c0d05);
      wr(OFS_CTRL, 32'h0000_0221);
      measure(hi, lo);
      chk(lo, p * (17 + idl));
      chk(hi, p * (4 + trk));
      wait_idle();
      rdc(OFS_FIFO, {12'h0, 4'h5, 4'h0, 8'hc3, 4'h5});
      rdc(OFS_FIFO, {12'h0, 4'hd, 4'h0, 8'hc3, 4'hd});
      rdc(OFS_FIFO, {12'h0, 4'hc, 4'h0, 8'hc3, 4'hc});
      rdc(OFS_FIFO, 32'h0);
   endtask

   task automatic cont_hw;
      int n;
      wr(OFS_CLKCTL, 32'h0000_0010);
      wr(OFS_SAMPCTL, 32'h0000_0004);
      wr(OFS_CHSEL0, 32'h0000_0001);
      wr(OFS_DIVSEL, 32'h0000_0008);
      wr(OFS_DYNPU, 32'h0000_0002);
      wr(OFS_CTRL, 32'h0000_0106);
      chk(div_enable[1], 1'b0);
      hw_trigger <= 1'b1;
      repeat (320) @(posedge hclk);
      chk({div_enable[1], div_large[1]}, 2'b11);
      wr(OFS_CTRL, 32'h0000_010e);
      wait_idle();
      n = rd[11:8];
      chk(n > 2, 1'b1);
      rdc(OFS_FIFO, {16'h0, 8'hc3, 4'h1, 4'h0});
      for (int i = 1; i < n; i++) ahb(1'b0, OFS_FIFO, 32'h0, rd);
      hw_trigger <= 1'b0;
      chk(div_enable[1], 1'b0);
   endtask

   task automatic divider_lp;
      wr(OFS_DIVSEL, 32'h0100_0001);
      wr(OFS_DYNPU, 32'h0);
      wr(OFS_LPCFG, 32'h0000_0001);
      repeat (2) @(posedge hclk);
      chk({div_enable[12], div_enable[0], div_large[0]}, 3'b110);
      low_power <= 1'b1;
      repeat (3) @(posedge hclk);
      chk({div_enable[12], div_enable[0]}, 2'b00);
      low_power <= 1'b0;
   endtask

   // right-aligned results; eleven pushes overrun the eight-deep fifo
   task automatic fifo_ovf;
      wr(OFS_CTRL, 32'h0000_0003);
      repeat (1000) @(posedge hclk);
      wr(OFS_CTRL, 32'h0000_000a);
      wait_idle();
      chk(rd[16:8], {1'h1, 2'h0, 1'h1, 1'h0, 4'h8});
      rdc(OFS_FIFO, {20'h0, 8'hc3, 4'h1});
      for (int i = 1; i < 8; i++) ahb(1'b0, OFS_FIFO, 32'h0, rd);
      wr(OFS_STATUS, 32'h0001_0000);
      rdc(OFS_STATUS, 32'h0000_1000);
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      reset_regs();
      seq_timing(SRC_SYS, 4'h1, 8'h05, 8'h02, 4);
      seq_timing(SRC_SYS, 4'h3, 8'h04, 8'h00, 16);
      seq_timing(SRC_EXT, 4'h4, 8'h04, 8'h01, 4);
      seq_timing(SRC_IOSC, 4'h5, 8'h04, 8'h00, 8);
      seq_timing(SRC_XOSC, 4'h0, 8'h04, 8'h00, 4);
      cont_hw();
      divider_lp();
      fifo_ovf();
      report_and_stop();
   end

   initial begin
      #500000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
